// File: rtl/sra_map.svh
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SRA_OFS_CTRL 8'h00
`define SRA_OFS_APPLY 8'h04
`define SRA_OFS_STATUS 8'h08
`define SRA_OFS_ACCEPT 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRA_CTRL_PATH_LSB 0
`define SRA_CTRL_DEFL_LSB 3
`define SRA_APPLY_BIT 0
`define SRA_ST_SHUT_LSB 0
`define SRA_ST_DEFL_LSB 3
`define SRA_ST_MODE_LSB 5
`define SRA_ST_INDEP_BIT 8
`define SRA_ST_START_BIT 9
`define SRA_ST_SCHED_LSB 10
`define SRA_ST_EXT_BIT 15
`define SRA_ST_OFFER_LSB 16

// Shutter configuration switch positions 6, 7 and 8 (bit 0 is position 1)
`define SRA_SW_POS6 5
`define SRA_SW_POS7 6
`define SRA_SW_POS8 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRA_RST_PATH 3'h0
`define SRA_RST_DEFL 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRA_CLK_MHZ 100
`define SRA_MS_NS 1000000
`define SRA_CLK_NS 10
`define SRA_ACC_T1_MS 1
`define SRA_ACC_T2_MS 4
`define SRA_ACC_T3_MS 8
`define SRA_ACC_T4_MS 16

`endif

// File: rtl/sra_pkg.sv
package sra_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRA_SINGLE,
    SRA_POWER2,
    SRA_POWER3,
    SRA_TIME2,
    SRA_TIME3,
    SRA_INDEP
  } sra_mode_t;

  typedef struct packed {
    logic [2:0] path;
    logic [1:0] defl;
  } sra_sel_t;

  typedef struct packed {
    logic start;
    logic [4:0] sched;
  } sra_ext_t;

endpackage

// File: rtl/sra_accept_filter.sv
// Accepts one input level once it has stood unchanged for limit cycles.
module sra_accept_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [20:0] limit,
  input wire logic din,
  output logic dout
);

  logic last_q, last_d;
  logic [20:0] cnt_q, cnt_d;
  logic out_q, out_d;

  always_comb begin
    last_d = din;
    cnt_d = cnt_q;
    out_d = out_q;
    if (!en) begin
      cnt_d = 21'h000000;
      out_d = 1'b0;
    end else if (din != last_q) begin
      // Any change restarts the wait, so short pulses never pass
      cnt_d = 21'h000000; // see [R17]
    end else begin
      if (cnt_q < limit) begin
        cnt_d = cnt_q + 21'h000001;
      end
      if (cnt_q >= limit - 21'h000001) begin
        out_d = last_q; // see [R17]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      cnt_q <= 21'h000000;
      out_q <= 1'b0;
    end else begin
      last_q <= last_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule // sra_accept_filter

// File: rtl/sra_top.sv
// Operation
// [R01] Shutter switch positions 6,7,8 decode 000 single, 001/010 two/three-way power split, 100/101 two/three-way time split.
// [R02] Single offers path selector one, two-way modes selectors one and two, three-way modes all three.
// [R03] Path selector n steers branch shutter n and input unit n.
// [R04] On confirmation each shutter with its selector on opens and every other stays closed.
// [R05] In time-split modes at most one shutter opens, the lowest-numbered selected one.
// [R06] In time-split modes an opened selected shutter operates its matching deflector with it; single and power-split modes drive no deflector.
// [R07] Positions 6,7,8 all on select independent mode, decoupling deflectors and offering two deflector selectors.
// [R08] In independent mode only fitted shutters enabled by their switch bit and selected are driven.
// [R09] In independent mode each deflector enabled by its switch and selected is operated.
// [R10] Acceptance switches 1,2 give ON/ON 1 ms, OFF/ON 4 ms, ON/OFF 8 ms, OFF/OFF 16 ms.
// [R11] Both acceptance switches off, the factory default, gives the longest time of 16 ms.
// [R12] One acceptance time serves both the start input and the schedule inputs.
// [R13] Laser output begins once the acceptance time has passed after the start input is asserted.
// [R14] The schedule number comes from five inputs weighted 1,2,4,8,16 and is set after the acceptance time.
// [R15] Acceptance qualification applies under external signal control, not panel control.
// [R16] The external controller holds start and schedule inputs steady for at least the acceptance time.
// [R17] An input is accepted only after standing at one level for the full acceptance time.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "sra_map.svh"

module sra_top #(
  parameter int MS_CYCLES = (`SRA_MS_NS / `SRA_CLK_NS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic [7:0] shutter_config_switches,
  input wire logic [7:0] deflector_config_switches,
  input wire logic [1:0] acceptance_config_switches,
  input wire logic ext_control,
  input wire logic ext_start,
  input wire logic [4:0] ext_sched,
  output logic [2:0] shutter_open,
  output logic [1:0] deflector_on,
  output logic laser_start,
  output logic [4:0] schedule_num
);

  // ----------------------------------------
  // Switch decode
  // ----------------------------------------
  logic [2:0] mode_code;
  sra_pkg::sra_mode_t mode;
  logic [2:0] offered;
  logic time_split;
  logic indep;

  assign mode_code = {shutter_config_switches[`SRA_SW_POS6],
                      shutter_config_switches[`SRA_SW_POS7],
                      shutter_config_switches[`SRA_SW_POS8]};

  always_comb begin
    case (mode_code) // see [R01]
      3'h0: mode = sra_pkg::SRA_SINGLE;
      3'h1: mode = sra_pkg::SRA_POWER2;
      3'h2: mode = sra_pkg::SRA_POWER3;
      3'h4: mode = sra_pkg::SRA_TIME2;
      3'h5: mode = sra_pkg::SRA_TIME3;
      3'h7: mode = sra_pkg::SRA_INDEP; // see [R07]
      // Unlisted codes fall back to single, the safest routing
      default: mode = sra_pkg::SRA_SINGLE;
    endcase
  end

  always_comb begin
    case (mode) // see [R02]
      sra_pkg::SRA_SINGLE: offered = 3'h1;
      sra_pkg::SRA_POWER2: offered = 3'h3;
      sra_pkg::SRA_TIME2: offered = 3'h3;
      sra_pkg::SRA_POWER3: offered = 3'h7;
      sra_pkg::SRA_TIME3: offered = 3'h7;
      sra_pkg::SRA_INDEP: offered = 3'h7;
      default: offered = 3'h1;
    endcase
  end

  assign time_split = (mode == sra_pkg::SRA_TIME2) || (mode == sra_pkg::SRA_TIME3);
  assign indep = (mode == sra_pkg::SRA_INDEP);

  // ----------------------------------------
  // Register bus: selections and apply
  // ----------------------------------------
  sra_pkg::sra_sel_t edit_q, edit_d;
  sra_pkg::sra_sel_t applied_q, applied_d;
  logic wr_ctrl;
  logic wr_apply;

  assign wr_ctrl = wr_en && (addr == `SRA_OFS_CTRL);
  assign wr_apply = wr_en && (addr == `SRA_OFS_APPLY) && wdata[`SRA_APPLY_BIT];

  always_comb begin
    edit_d = edit_q;
    applied_d = applied_q;
    if (wr_ctrl) begin
      edit_d.path = wdata[`SRA_CTRL_PATH_LSB +: 3];
      edit_d.defl = wdata[`SRA_CTRL_DEFL_LSB +: 2];
    end
    // A new selection moves the shutters only once it is confirmed
    if (wr_apply) begin
      applied_d = edit_q; // see [R04]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edit_q.path <= `SRA_RST_PATH;
      edit_q.defl <= `SRA_RST_DEFL;
      applied_q.path <= `SRA_RST_PATH;
      applied_q.defl <= `SRA_RST_DEFL;
    end else begin
      edit_q <= edit_d;
      applied_q <= applied_d;
    end
  end

  // ----------------------------------------
  // Shutter and deflector drive
  // ----------------------------------------
  logic [2:0] sel_eff;
  logic [2:0] shut_d, shut_q;
  logic [1:0] defl_d, defl_q;

  // Selectors the mode does not offer are ignored
  assign sel_eff = applied_q.path & offered; // see [R02]

  always_comb begin
    shut_d = 3'h0;
    defl_d = 2'h0;
    if (indep) begin
      // Unfitted shutters and deflectors stay idle even if selected
      shut_d = sel_eff & shutter_config_switches[2:0]; // see [R08]
      defl_d = applied_q.defl & deflector_config_switches[1:0]; // see [R09]
    end else if (time_split) begin
      // Lowest-numbered selection wins; two open shutters would split the beam
      if (sel_eff[0]) begin
        shut_d = 3'h1; // see [R05]
      end else if (sel_eff[1]) begin
        shut_d = 3'h2; // see [R05]
      end else if (sel_eff[2]) begin
        shut_d = 3'h4; // see [R05]
      end
      // Path one is straight through; paths two and three need a deflector
      defl_d = shut_d[2:1]; // see [R06]
    end else begin
      shut_d = sel_eff; // see [R03]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shut_q <= 3'h0;
      defl_q <= 2'h0;
    end else begin
      shut_q <= shut_d;
      defl_q <= defl_d;
    end
  end

  assign shutter_open = shut_q;
  assign deflector_on = defl_q;

  // ----------------------------------------
  // Acceptance time
  // ----------------------------------------
  logic [20:0] limit;

  always_comb begin
    // Switch bit high means ON; both off gives the factory 16 ms
    case (acceptance_config_switches) // see [R10]
      2'h3: limit = 21'(`SRA_ACC_T1_MS * MS_CYCLES);
      2'h2: limit = 21'(`SRA_ACC_T2_MS * MS_CYCLES);
      2'h1: limit = 21'(`SRA_ACC_T3_MS * MS_CYCLES);
      2'h0: limit = 21'(`SRA_ACC_T4_MS * MS_CYCLES); // see [R11]
      default: limit = 21'(`SRA_ACC_T4_MS * MS_CYCLES);
    endcase
  end

  // ----------------------------------------
  // External start and schedule inputs
  // ----------------------------------------
  sra_pkg::sra_ext_t raw;
  sra_pkg::sra_ext_t acc;

  assign raw.start = ext_start;
  assign raw.sched = ext_sched; // see [R14]

  // One filter per input, all sharing one limit
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_acc
      sra_accept_filter u_filt (
        .clk(clk),
        .rst_n(rst_n),
        .en(ext_control), // see [R15]
        .limit(limit), // see [R12]
        .din(raw[gi]),
        .dout(acc[gi])
      );
    end
  endgenerate

  logic start_q, start_d;
  logic [4:0] sched_q, sched_d;

  always_comb begin
    start_d = acc.start && ext_control; // see [R13]
    sched_d = sched_q;
    // Last accepted schedule is kept on return to panel control
    if (ext_control) begin
      sched_d = acc.sched; // see [R14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      sched_q <= 5'h00;
    end else begin
      start_q <= start_d;
      sched_q <= sched_d;
    end
  end

  assign laser_start = start_q;
  assign schedule_num = sched_q;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [31:0] rd_d, rd_q;

  always_comb begin
    rd_d = 32'h00000000;
    if (rd_en) begin
      case (addr)
        `SRA_OFS_CTRL: begin
          rd_d[`SRA_CTRL_PATH_LSB +: 3] = edit_q.path;
          rd_d[`SRA_CTRL_DEFL_LSB +: 2] = edit_q.defl;
        end
        `SRA_OFS_STATUS: begin
          rd_d[`SRA_ST_SHUT_LSB +: 3] = shut_q;
          rd_d[`SRA_ST_DEFL_LSB +: 2] = defl_q;
          rd_d[`SRA_ST_MODE_LSB +: 3] = mode_code;
          rd_d[`SRA_ST_INDEP_BIT] = indep;
          rd_d[`SRA_ST_START_BIT] = start_q;
          rd_d[`SRA_ST_SCHED_LSB +: 5] = sched_q;
          rd_d[`SRA_ST_EXT_BIT] = ext_control;
          rd_d[`SRA_ST_OFFER_LSB +: 3] = offered;
        end
        `SRA_OFS_ACCEPT: begin
          rd_d[20:0] = limit;
        end
        default: begin
          rd_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rdata = rd_q;

endmodule // sra_top

// File: verif/sra_checker.sv
module sra_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] shutter_config_switches,
  input wire logic [7:0] deflector_config_switches,
  input wire logic [1:0] acceptance_config_switches,
  input wire logic ext_control,
  input wire logic ext_start,
  input wire logic [2:0] shutter_open,
  input wire logic [1:0] deflector_on,
  input wire logic laser_start,
  input wire logic [4:0] schedule_num
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [2:0] m;
  logic [15:0] cfg_q, cfg_d;
  logic [20:0] run_q, run_d, lim;
  logic same, tm, pw;
  assign m = shutter_config_switches[7:5];
  assign same = cfg_q == cfg_d;
  assign tm = m == 3'h1 || m == 3'h5;
  assign pw = m == 3'h0 || m == 3'h2 || m == 3'h4;
  always_comb begin
    cfg_d = {deflector_config_switches, shutter_config_switches};
    run_d = (ext_control && ext_start) ? run_q + 21'(run_q != '1) : '0;
    case (acceptance_config_switches)
      2'h3: lim = 21'(MS_CYCLES);
      2'h2: lim = 21'(4 * MS_CYCLES);
      2'h1: lim = 21'(8 * MS_CYCLES);
      default: lim = 21'(16 * MS_CYCLES);
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
      run_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      run_q <= run_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  time_one_hot_a: assert property (tm && same |-> $onehot0(shutter_open))
    else $error("two shutters open in time split");
  time_defl_pair_a: assert property (tm && same |-> deflector_on == shutter_open[2:1])
    else $error("deflector not paired with shutter");
  power_no_defl_a: assert property (pw && same |-> deflector_on == 2'h0)
    else $error("deflector on in power split");
  single_path_a: assert property (m == 3'h0 && same |-> shutter_open[2:1] == 2'h0)
    else $error("extra shutter in single mode");
  two_way_path_a: assert property ((m == 3'h4 || m == 3'h1) && same |-> !shutter_open[2])
    else $error("third shutter in two way mode");
  indep_shutter_a: assert property (m == 3'h7 && same
    |-> (shutter_open & ~shutter_config_switches[2:0]) == 3'h0)
    else $error("unfitted shutter driven");
  indep_defl_a: assert property (m == 3'h7 && same
    |-> (deflector_on & ~deflector_config_switches[1:0]) == 2'h0)
    else $error("unfitted deflector driven");
  // Rise is seen one tick after the output edge, when the run has reached lim plus two
  start_needs_hold_a: assert property ($rose(laser_start) |-> run_q > lim)
    else $error("start accepted early");
  start_rise_bound_a: assert property (run_q == lim + 21'h2 |-> laser_start)
    else $error("start not accepted in time");
  ext_off_clear_a: assert property (!ext_control [*3] |-> !laser_start)
    else $error("start active under panel control");
  sched_ext_only_a: assert property (!$stable(schedule_num) |-> $past(ext_control))
    else $error("schedule changed without external control");
endmodule // sra_checker

bind sra_top sra_checker #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk(clk), .rst_n(rst_n), .shutter_config_switches(shutter_config_switches),
  .deflector_config_switches(deflector_config_switches),
  .acceptance_config_switches(acceptance_config_switches), .ext_control(ext_control),
  .ext_start(ext_start), .shutter_open(shutter_open), .deflector_on(deflector_on),
  .laser_start(laser_start), .schedule_num(schedule_num));

// File: verif/sra_plc_model.sv
module sra_plc_model (
  input wire logic clk,
  output logic ext_start,
  output logic [4:0] ext_sched
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_start = 1'b0;
    ext_sched = 5'h00;
  end
  // Levels are held for the given edges; callers pick shorter holds to test refusal
  task automatic send(input logic st, input logic [4:0] sc, input int n);
    ext_start <= st;
    ext_sched <= sc;
    repeat (n) @(posedge clk);
  endtask
endmodule // sra_plc_model

// File: verif/sra_top_test.sv
module sra_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 10;
  typedef struct packed {
    logic [7:0] sw;
    logic [7:0] dc;
    logic [4:0] ctl;
    logic [2:0] sh;
    logic [1:0] df;
  } sra_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00, sw = 8'h00, dcfg = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic wr_en = 1'b0, rd_en = 1'b0, ext_control = 1'b1, ext_start, laser_start;
  logic [1:0] acc = 2'h0, deflector_on;
  logic [4:0] ext_sched, schedule_num, s;
  logic [2:0] shutter_open;
  int err_count = 0, check_count = 0, lim;
  int ms [4] = '{1, 4, 8, 16};
  sra_row_t rows [10] = '{
    '{8'h00, 8'h03, 5'h1F, 3'h1, 2'h0}, '{8'h80, 8'h03, 5'h1F, 3'h3, 2'h0},
    '{8'h40, 8'h03, 5'h1F, 3'h7, 2'h0}, '{8'h20, 8'h03, 5'h06, 3'h2, 2'h1},
    '{8'hA0, 8'h03, 5'h04, 3'h4, 2'h2}, '{8'hA0, 8'h03, 5'h07, 3'h1, 2'h0},
    '{8'hA0, 8'h03, 5'h00, 3'h0, 2'h0}, '{8'hE5, 8'h02, 5'h1F, 3'h5, 2'h2},
    '{8'hE7, 8'h03, 5'h0A, 3'h2, 2'h1}, '{8'h20, 8'h03, 5'h1F, 3'h1, 2'h0}};
  always #5 clk = ~clk;
  sra_plc_model plc (.clk(clk), .ext_start(ext_start), .ext_sched(ext_sched));
  sra_top #(.MS_CYCLES(MSC)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .shutter_config_switches(sw), .deflector_config_switches(dcfg),
    .acceptance_config_switches(acc), .ext_control(ext_control), .ext_start(ext_start),
    .ext_sched(ext_sched), .shutter_open(shutter_open), .deflector_on(deflector_on),
    .laser_start(laser_start), .schedule_num(schedule_num));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd = rdata;
    @(posedge clk);
  endtask
  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    summarize();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1 chk("reset shutters", shutter_open, 0);
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk);
    rdr(8'h00);
    chk("ctrl reset", rd, 0);
    rdr(8'h40);
    chk("unmapped", rd, 0);
    foreach (rows[i]) begin
      sw <= rows[i].sw;
      dcfg <= rows[i].dc;
      wr(8'h00, {27'h0, rows[i].ctl});
      wr(8'h04, 32'h1);
      repeat (3) @(posedge clk);
      #1 chk("shutter", shutter_open, rows[i].sh);
      chk("deflector", deflector_on, rows[i].df);
      @(posedge clk);
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk("unconfirmed", shutter_open, 3'h1);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      acc <= 2'(3 - k);
      lim = MSC * ms[k];
      s = 5'(k * 9 + 3);
      rdr(8'h0C);
      chk("limit", rd, lim);
      plc.send(1'b1, s, lim - 1);
      #1 chk("early start", laser_start, 0);
      @(posedge clk);
      plc.send(1'b1, s, 3);
      #1 chk("start", laser_start, 1);
      chk("schedule", schedule_num, s);
      @(posedge clk);
      plc.send(1'b0, s, lim + 3);
      plc.send(1'b1, ~s, lim - 2);
      plc.send(1'b0, s, lim + 3);
      #1 chk("short start", laser_start, 0);
      chk("short schedule", schedule_num, s);
      @(posedge clk);
    end
    ext_control <= 1'b0;
    plc.send(1'b1, 5'h1F, 200);
    #1 chk("panel start", laser_start, 0);
    chk("panel schedule", schedule_num, 5'h1E);
    @(posedge clk);
    plc.send(1'b0, 5'h00, 2);
    rst_n <= 1'b0;
    #1 chk("rerun reset", schedule_num, 0);
    @(posedge clk) rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule // sra_top_test
